/* File: common/prcp_pkg.sv */
`default_nettype none
package prcp_pkg;
    // command codes of this bank
    localparam logic [7:0] CMD_CHIP_REVISION = 8'hae;
    localparam logic [7:0] CMD_LOOP_COMPENSATION = 8'hb1;
    localparam logic [7:0] CMD_POWER_STAGE_SETTINGS = 8'hb5;

    // block byte counts
    localparam logic [7:0] LEN_CHIP_REVISION = 8'h02;
    localparam logic [7:0] LEN_LOOP_COMPENSATION = 8'h05;
    localparam logic [7:0] LEN_POWER_STAGE_SETTINGS = 8'h01;

    // chip_revision fields
    localparam int REV_UPPER_MSB = 15;
    localparam int REV_UPPER_LSB = 12;
    localparam int REV_MIDDLE_MSB = 11;
    localparam int REV_MIDDLE_LSB = 8;
    localparam int REV_LOW_MSB = 7;
    localparam int REV_LOW_LSB = 0;

    // loop_compensation fields
    localparam int CI_LO_MSB = 39;
    localparam int CI_LO_LSB = 38;
    localparam int CF_MSB = 37;
    localparam int CF_LSB = 33;
    localparam int CI_DBL_BIT = 32;
    localparam int CR_MSB = 31;
    localparam int CR_LSB = 26;
    localparam int CI_HI_MSB = 25;
    localparam int CI_HI_LSB = 24;
    localparam int VI_LO_MSB = 23;
    localparam int VI_LO_LSB = 22;
    localparam int VF_MSB = 21;
    localparam int VF_LSB = 17;
    localparam int VR_MSB = 15;
    localparam int VR_LSB = 10;
    localparam int VI_HI_MSB = 9;
    localparam int VI_HI_LSB = 8;
    localparam int VG_MSB = 5;
    localparam int VG_LSB = 4;
    localparam int CG_MSB = 1;
    localparam int CG_LSB = 0;

    // power_stage_settings fields
    localparam int RAIL_MSB = 7;
    localparam int RAIL_LSB = 4;
    localparam logic [3:0] RAIL_CODE_MIN = 4'h3;
    localparam logic [3:0] RAIL_CODE_MAX = 4'ha;
    localparam logic [3:0] PSS_RESERVED_READ = 4'h0;

    // reset values, replaced when the nvm restore strobe arrives, and the byte read past the block end
    localparam logic [39:0] COMP_RESET = 40'h00_0000_0000;
    localparam logic [3:0] RAIL_RESET = 4'h8;
    localparam logic [7:0] RD_PAST_END = 8'hff;

    // transaction and action time limit
    localparam longint TXN_LIMIT_NS = 1000000;
    localparam longint CLK_PERIOD_NS = 8;
    localparam longint TXN_LIMIT_CYCLES = TXN_LIMIT_NS / CLK_PERIOD_NS;

    typedef enum {TXN_IDLE, TXN_ACTIVE} prcp_txn_e;

    typedef struct packed {
        logic [3:0] cur_int_cap_code;
        logic [4:0] cur_filter_cap_code;
        logic cur_int_cap_doubler;
        logic [5:0] cur_gain_res_code;
        logic [3:0] volt_int_cap_code;
        logic [4:0] volt_filter_cap_code;
        logic [5:0] volt_gain_res_code;
        logic [1:0] volt_transcond_code;
        logic [1:0] cur_transcond_code;
    } prcp_comp_s;

    typedef struct packed {
        logic comm_fault_summary;
        logic unsupported_cmd_flag;
    } prcp_fault_s;
endpackage
`default_nettype wire

/* File: hdl/prcp_regs.sv */
// Overview of operation
// R1 - revision command answers two bytes by block read; no write accepted.
// R2 - revision: upper nibble 15:12, middle nibble 11:8, low byte 7:0.
// R3 - writing a read-only command raises invalid-command fault, data discarded.
// R4 - fault sets comm fault summary bit and unsupported-command flag bit 7.
// R5 - fault notifies host by asserting the alert line until faults cleared.
// R6 - compensation carries five bytes, block write and block read.
// R7 - compensation writes stored during conversion but not passed to hardware.
// R8 - host disables conversion first to make compensation apply at once.
// R9 - otherwise host stores, clears override, then restores or cycles supply.
// R10 - current integrating cap code: bits 39:38 low half, 25:24 high half.
// R11 - current filter cap code from bits 37:33.
// R12 - bit 32 doubles the current integrating capacitor.
// R13 - current mid-band gain resistor code from bits 31:26.
// R14 - voltage integrating cap code from bits 23:22 low and 9:8 high.
// R15 - voltage filter cap code from bits 21:17.
// R16 - voltage mid-band gain resistor code from bits 15:10.
// R17 - bits 5:4 voltage transconductance, bits 1:0 current transconductance.
// R18 - host writes zero to reserved compensation bits 16, 7:6, 3:2.
// R19 - power stage byte still moves by block write and block read.
// R20 - power stage changes apply on the fly, within the 1.0 ms limits.
// R21 - power stage bits 7:4 select rail level, codes 3h to Ah valid.
// R22 - power stage bits 3:0 are reserved and read as zero.
// R23 - host avoids the lowest rail code unless the rail is fed externally.
// R24 - an invalid rail code leaves the applied rail level unchanged.
`timescale 1ns/1ns
`default_nettype none
module prcp_regs
    import prcp_pkg::*;
#(
    parameter logic [3:0] REV_UPPER = 4'h1, // arbitrary value
    parameter logic [3:0] REV_MIDDLE = 4'h0, // arbitrary value
    parameter logic [7:0] REV_LOW = 8'h00, // arbitrary value
    parameter int TXN_LIMIT = int'(TXN_LIMIT_CYCLES)
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_VALID,
    input wire logic [7:0] WR_DATA,
    input wire logic RD_REQ,
    input wire logic STOP,
    input wire logic CONV_EN,
    input wire logic CLEAR_FAULTS,
    input wire logic NVM_LOAD,
    input wire logic [39:0] NVM_COMP,
    input wire logic [3:0] NVM_RAIL,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output prcp_comp_s COMP_HW,
    output logic [3:0] RAIL_LEVEL,
    output prcp_fault_s FAULTS,
    output logic ALERT
);
    prcp_txn_e state;
    logic [7:0] cmd;
    logic [3:0] byte_idx;
    logic [7:0] wr_count;
    logic [39:0] wr_buf;
    logic [39:0] comp_reg;
    logic [39:0] comp_applied;
    logic [7:0] pss_reg;
    logic [3:0] rail_applied;
    logic [31:0] txn_timer;
    logic fault_summary;
    logic fault_unsup;

    wire logic [15:0] rev_word = {REV_UPPER, REV_MIDDLE, REV_LOW}; // [R2]
    wire logic is_rev = (cmd == CMD_CHIP_REVISION);
    wire logic is_comp = (cmd == CMD_LOOP_COMPENSATION);
    wire logic is_pss = (cmd == CMD_POWER_STAGE_SETTINGS);
    wire logic active = (state == TXN_ACTIVE);
    wire logic timed_out = active && (txn_timer >= 32'(TXN_LIMIT));
    // any data byte on the revision command is a write attempt
    wire logic ivc_event = active && is_rev && WR_VALID; // [R1] [R3]
    wire logic [39:0] wr_shift = {WR_DATA, wr_buf[39:8]};
    wire logic [3:0] data_seen = (byte_idx == 4'h0) ? 4'h0 : byte_idx - 4'h1;
    // commit only a complete block whose count matches the command
    wire logic comp_commit = active && STOP && is_comp && !timed_out
        && (wr_count == LEN_LOOP_COMPENSATION)
        && (data_seen == LEN_LOOP_COMPENSATION[3:0]); // [R6]
    wire logic pss_commit = active && STOP && is_pss && !timed_out
        && (wr_count == LEN_POWER_STAGE_SETTINGS)
        && (data_seen == LEN_POWER_STAGE_SETTINGS[3:0]); // [R19]
    wire logic [7:0] pss_new = wr_buf[39:32];
    wire logic [3:0] rail_new = pss_new[RAIL_MSB:RAIL_LSB];
    wire logic rail_ok = (rail_new >= RAIL_CODE_MIN) && (rail_new <= RAIL_CODE_MAX); // [R21]
    // conversion running blocks the hardware copy
    wire logic comp_to_hw = comp_commit && !CONV_EN; // [R7] [R8]

    // readable images, block count byte first, then data low byte first
    wire logic [39:0] rd_image = is_rev ? {24'h0, rev_word} :
        is_comp ? comp_reg : {32'h0, pss_reg[RAIL_MSB:RAIL_LSB], PSS_RESERVED_READ}; // [R22]
    wire logic [7:0] rd_len = is_rev ? LEN_CHIP_REVISION :
        is_comp ? LEN_LOOP_COMPENSATION : LEN_POWER_STAGE_SETTINGS;
    wire logic [39:0] rd_shifted = rd_image >> {data_seen, 3'b000};
    wire logic rd_known = is_rev || is_comp || is_pss;
    wire logic [7:0] next_rd_data = (byte_idx == 4'h0) ? rd_len :
        ({4'h0, data_seen} < rd_len) ? rd_shifted[7:0] : RD_PAST_END;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state <= TXN_IDLE;
            cmd <= 8'h00;
            byte_idx <= 4'h0;
            wr_count <= 8'h00;
            wr_buf <= 40'h00_0000_0000;
            txn_timer <= 32'h0;
        end else if (CMD_VALID) begin
            state <= TXN_ACTIVE;
            cmd <= CMD_CODE;
            byte_idx <= 4'h0;
            wr_count <= 8'h00;
            txn_timer <= 32'h0;
        end else if (STOP || timed_out) begin
            // a stalled transaction is dropped past the time limit
            state <= TXN_IDLE; // [R20]
        end else if (active) begin
            txn_timer <= txn_timer + 32'h1;
            if (WR_VALID || RD_REQ) begin
                byte_idx <= (byte_idx == 4'hf) ? byte_idx : byte_idx + 4'h1;
            end
            if (WR_VALID && byte_idx == 4'h0) begin
                wr_count <= WR_DATA;
            end else if (WR_VALID) begin
                wr_buf <= wr_shift;
            end
        end
    end

    // with a full five-byte block the buffer already sits aligned
    wire logic [39:0] comp_word = wr_buf;
    // a one-byte block leaves its byte in the top lane, as pss_new picks it

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            comp_reg <= COMP_RESET;
            comp_applied <= COMP_RESET;
            pss_reg <= {RAIL_RESET, PSS_RESERVED_READ};
            rail_applied <= RAIL_RESET;
        end else if (NVM_LOAD) begin
            // restore is the path that applies values written while converting
            comp_reg <= NVM_COMP;
            comp_applied <= NVM_COMP; // [R9]
            pss_reg <= {NVM_RAIL, PSS_RESERVED_READ};
            rail_applied <= NVM_RAIL;
        end else begin
            if (comp_commit) begin
                comp_reg <= comp_word; // [R18]
            end
            if (comp_to_hw) begin
                comp_applied <= comp_word; // [R7]
            end
            if (pss_commit) begin
                pss_reg <= {rail_new, PSS_RESERVED_READ}; // [R22]
            end
            if (pss_commit && rail_ok) begin
                rail_applied <= rail_new; // [R20] [R24]
            end
        end
    end

    // set wins over clear so a fault in the clearing cycle survives
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            fault_summary <= 1'b0;
            fault_unsup <= 1'b0;
        end else begin
            fault_summary <= ivc_event || (fault_summary && !CLEAR_FAULTS); // [R4]
            fault_unsup <= ivc_event || (fault_unsup && !CLEAR_FAULTS); // [R4]
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            RD_DATA <= 8'h00;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= active && RD_REQ && rd_known; // [R1]
            if (active && RD_REQ && rd_known) begin
                RD_DATA <= next_rd_data;
            end
        end
    end

    assign COMP_HW.cur_int_cap_code = {comp_applied[CI_HI_MSB:CI_HI_LSB],
        comp_applied[CI_LO_MSB:CI_LO_LSB]}; // [R10]
    assign COMP_HW.cur_filter_cap_code = comp_applied[CF_MSB:CF_LSB]; // [R11]
    assign COMP_HW.cur_int_cap_doubler = comp_applied[CI_DBL_BIT]; // [R12]
    assign COMP_HW.cur_gain_res_code = comp_applied[CR_MSB:CR_LSB]; // [R13]
    assign COMP_HW.volt_int_cap_code = {comp_applied[VI_HI_MSB:VI_HI_LSB],
        comp_applied[VI_LO_MSB:VI_LO_LSB]}; // [R14]
    assign COMP_HW.volt_filter_cap_code = comp_applied[VF_MSB:VF_LSB]; // [R15]
    assign COMP_HW.volt_gain_res_code = comp_applied[VR_MSB:VR_LSB]; // [R16]
    assign COMP_HW.volt_transcond_code = comp_applied[VG_MSB:VG_LSB]; // [R17]
    assign COMP_HW.cur_transcond_code = comp_applied[CG_MSB:CG_LSB]; // [R17]
    assign RAIL_LEVEL = rail_applied;
    assign FAULTS.comm_fault_summary = fault_summary;
    assign FAULTS.unsupported_cmd_flag = fault_unsup;
    assign ALERT = fault_summary || fault_unsup; // [R5]
endmodule
`default_nettype wire

/* File: sim/prcp_host.sv */
`timescale 1ns/1ns
`default_nettype none
module prcp_host (
    input wire logic MCLK,
    input wire logic [7:0] RD_DATA,
    input wire logic RD_VALID,
    output logic CMD_VALID,
    output logic [7:0] CMD_CODE,
    output logic WR_VALID,
    output logic [7:0] WR_DATA,
    output logic RD_REQ,
    output logic STOP
);
    initial {CMD_VALID, CMD_CODE, WR_VALID, WR_DATA, RD_REQ, STOP} = '0;
    task automatic start(input logic [7:0] c);
        @(negedge MCLK);
        CMD_CODE = c;
        CMD_VALID = 1'h1;
        @(negedge MCLK);
        CMD_VALID = 1'h0;
    endtask
    task automatic wr(input logic [7:0] c, input int n, input logic [39:0] d, input int gap);
        start(c);
        WR_VALID = 1'h1;
        WR_DATA = 8'(n);
        for (int i = 0; i < n; i++) begin
            @(negedge MCLK);
            WR_DATA = d[8*i+:8];
        end
        @(negedge MCLK);
        WR_VALID = 1'h0;
        // released data must not keep its last value
        WR_DATA = ~WR_DATA;
        repeat (gap) @(negedge MCLK);
        STOP = 1'h1;
        @(negedge MCLK);
        STOP = 1'h0;
    endtask
    task automatic rd(input logic [7:0] c, input int n, output logic [47:0] q);
        q = '0;
        start(c);
        RD_REQ = 1'h1;
        for (int i = 0; i <= n; i++) begin
            @(negedge MCLK);
            q[8*i+:8] = RD_VALID ? RD_DATA : 8'hxx;
        end
        RD_REQ = 1'h0;
        STOP = 1'h1;
        @(negedge MCLK);
        STOP = 1'h0;
    endtask
endmodule
`default_nettype wire

/* File: sim/prcp_regs_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module prcp_regs_chk
    import prcp_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_VALID,
    input wire logic RD_REQ,
    input wire logic STOP,
    input wire logic CONV_EN,
    input wire logic CLEAR_FAULTS,
    input wire logic NVM_LOAD,
    input wire logic [7:0] RD_DATA,
    input wire logic RD_VALID,
    input wire prcp_comp_s COMP_HW,
    input wire logic [3:0] RAIL_LEVEL,
    input wire prcp_fault_s FAULTS,
    input wire logic ALERT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    sequence rev_read;
        CMD_VALID && CMD_CODE == CMD_CHIP_REVISION ##1 RD_REQ && !CMD_VALID;
    endsequence
    sequence rev_write;
        CMD_VALID && CMD_CODE == CMD_CHIP_REVISION ##1 WR_VALID && !CMD_VALID && !STOP;
    endsequence
    chk_fault_set: assert property (rev_write |=> FAULTS == 2'h3 && ALERT)
        else $error("write to revision raised no fault");
    chk_comp_hold: assert property (CONV_EN && !NVM_LOAD |=> $stable(COMP_HW))
        else $error("compensation reached hardware while converting");
    chk_rev_count: assert property (rev_read |=> RD_VALID && RD_DATA == LEN_CHIP_REVISION)
        else $error("revision count byte wrong");
    chk_read_latency: assert property (RD_VALID |-> $past(RD_REQ))
        else $error("read byte without request");
    chk_alert_level: assert property (ALERT == (FAULTS != 2'h0))
        else $error("alert does not follow faults");
    chk_fault_pair: assert property (FAULTS.comm_fault_summary == FAULTS.unsupported_cmd_flag)
        else $error("fault bits disagree");
    chk_fault_cause: assert property ($rose(FAULTS.unsupported_cmd_flag) |-> $past(WR_VALID))
        else $error("fault without written byte");
    chk_fault_clear: assert property (CLEAR_FAULTS && !WR_VALID |=> FAULTS == 2'h0)
        else $error("faults not cleared");
    chk_comp_block: assert property ($changed(COMP_HW) |->
        $past(NVM_LOAD) || $past(STOP) && !$past(CONV_EN)) else $error("compensation applied");
    chk_rail_apply: assert property ($changed(RAIL_LEVEL) |->
        RAIL_LEVEL inside {[RAIL_CODE_MIN:RAIL_CODE_MAX]} && ($past(STOP) || $past(NVM_LOAD)))
        else $error("rail level change wrong");
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb
    import prcp_pkg::*;
;
    typedef struct packed {
        logic [7:0] cmd;
        logic conv;
        logic [39:0] d;
        logic [39:0] hw;
        logic [3:0] rail;
    } prcp_row_s;
    // reserved compensation bits zero in every value
    // lowest rail code kept out, the rail is not fed externally here
    prcp_row_s rows[6] = '{
        '{8'hb1, 1'h0, 40'h5ac3963c33, 40'h5ac3963c33, 4'h8},
        '{8'hb1, 1'h1, 40'h0f0ca4fc21, 40'h5ac3963c33, 4'h8},
        '{8'hb5, 1'h0, 40'h20, 40'h5ac3963c33, 4'h8},
        '{8'hb5, 1'h0, 40'h40, 40'h5ac3963c33, 4'h4},
        '{8'hb5, 1'h0, 40'ha5, 40'h5ac3963c33, 4'ha},
        '{8'hb5, 1'h0, 40'hb0, 40'h5ac3963c33, 4'ha}};
    logic mclk = 1'h0, srst = 1'h1, conv_en = 1'h0, clear_faults = 1'h0, nvm_load = 1'h0;
    logic [39:0] nvm_comp = 40'h0;
    logic [3:0] nvm_rail = 4'h0, rail_level;
    logic cmd_valid, wr_valid, rd_req, stop, rd_valid, alert;
    logic [7:0] cmd_code, wr_data, rd_data;
    logic [47:0] q;
    prcp_comp_s comp_hw;
    prcp_fault_s faults;
    int mismatches = 0, checked = 0, n;
    prcp_host prcp_host_inst (.MCLK(mclk), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .WR_VALID(wr_valid),
        .WR_DATA(wr_data), .RD_REQ(rd_req), .STOP(stop));
    prcp_regs #(.REV_UPPER(4'h3), .REV_MIDDLE(4'hc), .REV_LOW(8'h5a), .TXN_LIMIT(50))
    prcp_regs_inst (.MCLK(mclk), .SRST(srst), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
        .WR_VALID(wr_valid), .WR_DATA(wr_data), .RD_REQ(rd_req), .STOP(stop),
        .CONV_EN(conv_en), .CLEAR_FAULTS(clear_faults), .NVM_LOAD(nvm_load),
        .NVM_COMP(nvm_comp), .NVM_RAIL(nvm_rail), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .COMP_HW(comp_hw), .RAIL_LEVEL(rail_level), .FAULTS(faults), .ALERT(alert));
    function automatic prcp_comp_s fm(input logic [39:0] d);
        return {d[25:24], d[39:38], d[37:33], d[32], d[31:26], d[9:8], d[23:22],
            d[21:17], d[15:10], d[5:4], d[1:0]};
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial forever #4 mclk = ~mclk;
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (20) @(negedge mclk);
        srst = 1'h0;
        @(negedge mclk);
        chk({rail_level, comp_hw, faults, alert, rd_valid}, {4'h8, 39'h0});
        foreach (rows[i]) begin
            n = rows[i].cmd == CMD_LOOP_COMPENSATION ? 5 : 1;
            conv_en = rows[i].conv;
            prcp_host_inst.wr(rows[i].cmd, n, rows[i].d, 0);
            chk({comp_hw, rail_level}, {fm(rows[i].hw), rows[i].rail});
            prcp_host_inst.rd(rows[i].cmd, n, q);
            chk(q, n == 5 ? {rows[i].d, 8'h05} : {32'h0, rows[i].d[7:4], 12'h001});
        end
        // a block whose count does not match the command is ignored
        prcp_host_inst.wr(CMD_LOOP_COMPENSATION, 1, 40'hff, 0);
        chk({comp_hw, rail_level}, {fm(40'h5ac3963c33), 4'ha});
        prcp_host_inst.rd(CMD_POWER_STAGE_SETTINGS, 2, q);
        chk(q, 48'hffb001);
        prcp_host_inst.rd(CMD_CHIP_REVISION, 2, q);
        chk(q, 48'h3c5a02);
        prcp_host_inst.wr(CMD_CHIP_REVISION, 2, 40'h0, 0);
        chk({faults, alert}, 3'h7);
        prcp_host_inst.rd(CMD_CHIP_REVISION, 2, q);
        chk(q, 48'h3c5a02);
        clear_faults = 1'h1;
        @(negedge mclk);
        clear_faults = 1'h0;
        chk({faults, alert}, 3'h0);
        prcp_host_inst.rd(8'hb2, 0, q);
        chk(q[7:0], 8'hxx);
        prcp_host_inst.wr(CMD_POWER_STAGE_SETTINGS, 1, 40'h40, 60);
        chk(rail_level, 4'ha);
        // restore path applies even while converting
        conv_en = 1'h1;
        nvm_comp = 40'h1234567833;
        nvm_rail = 4'h5;
        nvm_load = 1'h1;
        @(negedge mclk);
        nvm_load = 1'h0;
        chk({comp_hw, rail_level}, {fm(nvm_comp), 4'h5});
        srst = 1'h1;
        repeat (2) @(negedge mclk);
        srst = 1'h0;
        chk({rail_level, comp_hw}, {4'h8, 35'h0});
        stop_test();
    end
endmodule
bind prcp_regs prcp_regs_chk prcp_regs_chk_inst (.MCLK(MCLK), .SRST(SRST),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .WR_VALID(WR_VALID), .RD_REQ(RD_REQ),
    .STOP(STOP), .CONV_EN(CONV_EN), .CLEAR_FAULTS(CLEAR_FAULTS), .NVM_LOAD(NVM_LOAD),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .COMP_HW(COMP_HW), .RAIL_LEVEL(RAIL_LEVEL),
    .FAULTS(FAULTS), .ALERT(ALERT));
`default_nettype wire
